/* inc/arcr_consts.svh */
// Constants of the rate-converter routing and ADC pair 0 control registers.
// Assumes inclusion by bare name from files that use these offsets and fields.
`ifndef ARCR_CONSTS_SVH
`define ARCR_CONSTS_SVH

// Register offsets on the control port
`define ARCR_ADDR_SRC23 8'h19
`define ARCR_ADDR_MODE 8'h1A
`define ARCR_ADDR_ADC0 8'h1B

// Reset values
`define ARCR_RST_SRC23 8'h32
`define ARCR_RST_MODE 8'h00
`define ARCR_RST_ADC0 8'h19
`define ARCR_RST_FS 2'h1
`define ARCR_RST_SINC 1'h0
`define ARCR_RST_ATTEN 2'h3
`define ARCR_RST_SRC_IDX 6'h1A
`define ARCR_ZERO8 8'h00

// Source register fields
`define ARCR_SRC3_MSB 7
`define ARCR_SRC3_LSB 4
`define ARCR_SRC2_MSB 3
`define ARCR_SRC2_LSB 0

// Mode register fields
`define ARCR_PAIR_MSB 3
`define ARCR_PAIR_LSB 2
`define ARCR_OUT_EN_BIT 1
`define ARCR_IN_EN_BIT 0

// ADC pair 0 control fields
`define ARCR_SINC_BIT 5
`define ARCR_MUTE1_BIT 4
`define ARCR_MUTE0_BIT 3
`define ARCR_FS_MSB 1
`define ARCR_FS_LSB 0

// Source code layout: bit 3 marks serial, bit 2 marks ADC
`define ARCR_CODE_SERIAL_BIT 3
`define ARCR_CODE_ADC_BIT 2

`endif

/* inc/arcr_pkg.sv */
// Types shared by the rate-converter routing register bank.
// Assumes arcr_consts.svh supplies offsets and fields.
package arcr_pkg;

  // Class of a rate converter source
  typedef enum logic [1:0] {
    ARCR_CLS_CORE = 2'b00,
    ARCR_CLS_ADC = 2'b01,
    ARCR_CLS_SERIAL = 2'b10
  } arcr_src_cls_t;

  // ADC pair sample rate codes
  typedef enum logic [1:0] {
    ARCR_FS_96K = 2'b00,
    ARCR_FS_192K = 2'b01,
    ARCR_FS_768K = 2'b10,
    ARCR_FS_RSVD = 2'b11
  } arcr_fs_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0] src23;
    logic [7:0] mode;
    logic [7:0] adc0;
    logic sinc_eff;
    logic [1:0] fs_eff;
    logic [1:0] atten_max;
    logic [1:0][1:0] src_cls;
    logic [1:0][2:0] src_idx;
    logic [7:0] rd_data;
    logic rd_valid;
  } arcr_state_t;

endpackage

/* src/arcr_src_decode.sv */
// Decoder of one four-bit rate converter source code into class and index.
// Assumes a registered code at its input; purely combinational.
`timescale 1ns/1ns
`include "arcr_consts.svh"

module arcr_src_decode (
  input wire logic [3:0] code_i,
  output arcr_pkg::arcr_src_cls_t cls_o,
  output logic [2:0] index_o
);
  import arcr_pkg::*;

  // Serial codes use three index bits, core and ADC codes only two
  always_comb begin
    if (code_i[`ARCR_CODE_SERIAL_BIT]) begin
      cls_o = ARCR_CLS_SERIAL;
      index_o = code_i[2:0];
    end else if (code_i[`ARCR_CODE_ADC_BIT]) begin
      cls_o = ARCR_CLS_ADC;
      index_o = {1'b0, code_i[1:0]};
    end else begin
      cls_o = ARCR_CLS_CORE;
      index_o = {1'b0, code_i[1:0]};
    end
  end

endmodule

/* src/arcr_regs.sv */
// Register bank for output converter ch2/ch3 routing, converter mode and
// ADC pair 0 control. Assumes a single-cycle strobe master on the control
// port, and core-run and volume-bypass levels synchronous to clk_sys_i.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "arcr_consts.svh"

// Functional notes
// (R01) The upper nibble of the source register picks output converter ch3's source, reset 3.
// (R02) The lower nibble picks output converter ch2's source with the same coding, reset 2.
// (R03) Mode bits 3:2 pick the serial input pair feeding the input converter, reset 00.
// (R04) Mode bit 1 enables the output converter and bit 0 the input converter, both reset off.
// (R05) ADC control bit 5 selects fourth order sinc at 0 and third order at 1, reset 0.
// (R06) Software changes the sinc order only with the core stopped; it is taken over only then.
// (R07) Bits 4 and 3 mute ADC1 and ADC0, reset muted, by forcing maximum attenuation.
// (R08) A channel whose volume control is bypassed ignores its mute bit.
// (R09) ADC control bits 1:0 set 96, 192 or 768 kHz, code 11 reserved, reset 192 kHz.
// (R10) Software changes the sample rate only with the core stopped; it is applied only then.
// (R11) Reserved bits of the ADC control and mode registers are read/write and reset to 0.
// (R12) The reserved rate code is never programmed; if it is, the previous rate is held.
module arcr_regs (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic core_run_i,
  input wire logic [1:0] vol_bypass_i,
  output logic [3:0] out_conv_ch2_source_o,
  output logic [3:0] out_conv_ch3_source_o,
  output logic [1:0][1:0] out_conv_src_cls_o,
  output logic [1:0][2:0] out_conv_src_idx_o,
  output logic [1:0] in_conv_pair_select_o,
  output logic out_conv_enable_o,
  output logic in_conv_enable_o,
  output logic adc_sinc_third_o,
  output arcr_pkg::arcr_fs_t adc_pair0_sample_rate_o,
  output logic adc_ch0_mute_o,
  output logic adc_ch1_mute_o,
  output logic [1:0] adc_ch_atten_max_o
);
  import arcr_pkg::*;

  arcr_state_t state_ff;
  arcr_state_t nxt_state;
  arcr_src_cls_t dec_cls [1:0];
  logic [2:0] dec_idx [1:0];
  logic [1:0] mute_bits;

  // Address decode of the three writable registers
  logic wr_src23;
  logic wr_mode;
  logic wr_adc0;
  assign wr_src23 = wr_en_i && (addr_i == `ARCR_ADDR_SRC23);
  assign wr_mode = wr_en_i && (addr_i == `ARCR_ADDR_MODE);
  assign wr_adc0 = wr_en_i && (addr_i == `ARCR_ADDR_ADC0);

  // One decoder per routed converter channel, 0 is ch2 and 1 is ch3
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dec
      arcr_src_decode u_dec (
        .code_i(state_ff.src23[gi*4 +: 4]), // see (R01) see (R02)
        .cls_o(dec_cls[gi]),
        .index_o(dec_idx[gi])
      );
    end
  endgenerate

  // Next state: register writes, held settings, attenuation and read port
  always_comb begin
    nxt_state = state_ff;
    // Full eight bits stored, reserved ones included
    if (wr_src23) begin
      nxt_state.src23 = wr_data_i; // see (R01) see (R02)
    end
    if (wr_mode) begin
      nxt_state.mode = wr_data_i; // see (R03) see (R04) see (R11)
    end
    if (wr_adc0) begin
      nxt_state.adc0 = wr_data_i; // see (R11)
    end
    // Filter order only follows the register while the core is stopped
    if (!core_run_i) begin
      nxt_state.sinc_eff = nxt_state.adc0[`ARCR_SINC_BIT]; // see (R05) see (R06)
    end
    // Rate follows likewise, and a reserved code keeps the old rate
    if (!core_run_i && (nxt_state.adc0[`ARCR_FS_MSB:`ARCR_FS_LSB] != ARCR_FS_RSVD)) begin
      nxt_state.fs_eff = nxt_state.adc0[`ARCR_FS_MSB:`ARCR_FS_LSB]; // see (R09) see (R10) see (R12)
    end
    // Mute drives full attenuation unless the volume stage is bypassed
    nxt_state.atten_max[0] = nxt_state.adc0[`ARCR_MUTE0_BIT] && !vol_bypass_i[0]; // see (R07) see (R08)
    nxt_state.atten_max[1] = nxt_state.adc0[`ARCR_MUTE1_BIT] && !vol_bypass_i[1]; // see (R07) see (R08)
    // Decoded routing is registered, trading one cycle for clean outputs
    for (int i = 0; i < 2; i++) begin
      nxt_state.src_cls[i] = dec_cls[i];
      nxt_state.src_idx[i] = dec_idx[i];
    end
    // Read data lives only in the cycle after the strobe
    nxt_state.rd_valid = rd_en_i;
    nxt_state.rd_data = `ARCR_ZERO8;
    if (rd_en_i) begin
      unique case (addr_i)
        `ARCR_ADDR_SRC23: begin
          nxt_state.rd_data = state_ff.src23;
        end
        `ARCR_ADDR_MODE: begin
          nxt_state.rd_data = state_ff.mode;
        end
        `ARCR_ADDR_ADC0: begin
          nxt_state.rd_data = state_ff.adc0;
        end
        default: begin
          nxt_state.rd_data = `ARCR_ZERO8; // Unmapped reads as zero
        end
      endcase
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff.src23 <= `ARCR_RST_SRC23; // see (R01) see (R02)
      state_ff.mode <= `ARCR_RST_MODE; // see (R03) see (R04) see (R11)
      state_ff.adc0 <= `ARCR_RST_ADC0; // see (R07) see (R11)
      state_ff.sinc_eff <= `ARCR_RST_SINC;
      state_ff.fs_eff <= `ARCR_RST_FS;
      state_ff.atten_max <= `ARCR_RST_ATTEN;
      state_ff.src_cls <= {ARCR_CLS_CORE, ARCR_CLS_CORE};
      state_ff.src_idx <= `ARCR_RST_SRC_IDX;
      state_ff.rd_data <= `ARCR_ZERO8;
      state_ff.rd_valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register
  assign rd_data_o = state_ff.rd_data;
  assign rd_valid_o = state_ff.rd_valid;
  assign out_conv_ch2_source_o = state_ff.src23[`ARCR_SRC2_MSB:`ARCR_SRC2_LSB];
  assign out_conv_ch3_source_o = state_ff.src23[`ARCR_SRC3_MSB:`ARCR_SRC3_LSB];
  assign out_conv_src_cls_o = state_ff.src_cls;
  assign out_conv_src_idx_o = state_ff.src_idx;
  assign in_conv_pair_select_o = state_ff.mode[`ARCR_PAIR_MSB:`ARCR_PAIR_LSB];
  assign out_conv_enable_o = state_ff.mode[`ARCR_OUT_EN_BIT];
  assign in_conv_enable_o = state_ff.mode[`ARCR_IN_EN_BIT];
  assign adc_sinc_third_o = state_ff.sinc_eff;
  assign adc_pair0_sample_rate_o = arcr_fs_t'(state_ff.fs_eff);
  assign mute_bits = {state_ff.adc0[`ARCR_MUTE1_BIT], state_ff.adc0[`ARCR_MUTE0_BIT]};
  assign adc_ch0_mute_o = mute_bits[0];
  assign adc_ch1_mute_o = mute_bits[1];
  assign adc_ch_atten_max_o = state_ff.atten_max;

  // Ch3 serial codes decode to the serial class with the low three bits
  AST_CH3_SERIAL: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R01)
    out_conv_ch3_source_o[`ARCR_CODE_SERIAL_BIT] |=>
      (out_conv_src_cls_o[1] == ARCR_CLS_SERIAL) &&
      (out_conv_src_idx_o[1] == $past(out_conv_ch3_source_o[2:0])))
    else $error("ch3 serial source decoded wrongly");

  // Ch2 ADC codes decode to the ADC class
  AST_CH2_ADC: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R02)
    (out_conv_ch2_source_o[3:2] == 2'b01) |=>
      (out_conv_src_cls_o[0] == ARCR_CLS_ADC) &&
      (out_conv_src_idx_o[0] == {1'b0, $past(out_conv_ch2_source_o[1:0])}))
    else $error("ch2 ADC source decoded wrongly");

  // A source write shows on both nibbles at the next edge
  AST_SRC_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R01)
    wr_src23 |=> {out_conv_ch3_source_o, out_conv_ch2_source_o} == $past(wr_data_i))
    else $error("source register write not taken");

  // Pair select follows a mode write
  AST_PAIR_SEL: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R03)
    wr_mode |=> in_conv_pair_select_o == $past(wr_data_i[`ARCR_PAIR_MSB:`ARCR_PAIR_LSB]))
    else $error("pair select not updated");

  // Both enables follow their own bits
  AST_ENABLES: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R04)
    wr_mode |=> (out_conv_enable_o == $past(wr_data_i[`ARCR_OUT_EN_BIT])) &&
      (in_conv_enable_o == $past(wr_data_i[`ARCR_IN_EN_BIT])))
    else $error("converter enables not updated");

  // With the core stopped a sinc write takes effect at once
  AST_SINC_STOPPED: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R05)
    (wr_adc0 && !core_run_i) |=> adc_sinc_third_o == $past(wr_data_i[`ARCR_SINC_BIT]))
    else $error("sinc order not taken while stopped");

  // While the core runs the applied order and rate stand still
  AST_RUN_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R06)
    core_run_i |=> $stable(adc_sinc_third_o) && $stable(adc_pair0_sample_rate_o))
    else $error("order or rate changed while core runs");

  // Attenuation is the mute bit gated by the bypass level
  AST_ATTEN: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R07)
    1'b1 |=> (adc_ch_atten_max_o[0] == (adc_ch0_mute_o && !$past(vol_bypass_i[0]))) &&
      (adc_ch_atten_max_o[1] == (adc_ch1_mute_o && !$past(vol_bypass_i[1]))))
    else $error("attenuation does not follow mute");

  // Bypassed ch1 is never attenuated
  AST_BYPASS: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R08)
    vol_bypass_i[1] |=> !adc_ch_atten_max_o[1])
    else $error("bypassed channel attenuated");

  // A valid rate written while stopped is applied next edge
  AST_FS_APPLY: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R09)
    (wr_adc0 && !core_run_i && (wr_data_i[1:0] != 2'b11)) |=>
      adc_pair0_sample_rate_o == $past(wr_data_i[1:0]))
    else $error("sample rate not applied");

  // A reserved rate code leaves the applied rate untouched
  AST_FS_RSVD: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R12)
    (wr_adc0 && (wr_data_i[1:0] == 2'b11)) |=> $stable(adc_pair0_sample_rate_o))
    else $error("reserved rate code changed the rate");

  // Reserved mode bits read back what was written
  AST_RSVD_RW: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R11)
    (wr_mode && !rd_en_i) ##1 (rd_en_i && !wr_en_i && (addr_i == `ARCR_ADDR_MODE)) |=>
      rd_valid_o && (rd_data_o == $past(wr_data_i, 2)))
    else $error("mode register readback mismatch");

  // Freshly bypassed ch0 drops its attenuation at the next edge
  AST_BYPASS0: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R08)
    vol_bypass_i[0] |=> !adc_ch_atten_max_o[0])
    else $error("bypassed channel 0 attenuated");

  // Ch3 core codes keep their two index bits
  AST_CH3_CORE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R01)
    (out_conv_ch3_source_o[3:2] == 2'b00) |=>
      (out_conv_src_cls_o[1] == ARCR_CLS_CORE) &&
      (out_conv_src_idx_o[1] == {1'b0, $past(out_conv_ch3_source_o[1:0])}))
    else $error("ch3 core source decoded wrongly");

  // Ch3 ADC codes decode to the ADC class
  AST_CH3_ADC: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R01)
    (out_conv_ch3_source_o[3:2] == 2'b01) |=>
      (out_conv_src_cls_o[1] == ARCR_CLS_ADC) &&
      (out_conv_src_idx_o[1] == {1'b0, $past(out_conv_ch3_source_o[1:0])}))
    else $error("ch3 ADC source decoded wrongly");

  // Ch2 serial codes carry all three index bits
  AST_CH2_SERIAL: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R02)
    out_conv_ch2_source_o[`ARCR_CODE_SERIAL_BIT] |=>
      (out_conv_src_cls_o[0] == ARCR_CLS_SERIAL) &&
      (out_conv_src_idx_o[0] == $past(out_conv_ch2_source_o[2:0])))
    else $error("ch2 serial source decoded wrongly");

  // Ch2 core codes decode to the core class
  AST_CH2_CORE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R02)
    (out_conv_ch2_source_o[3:2] == 2'b00) |=>
      (out_conv_src_cls_o[0] == ARCR_CLS_CORE) &&
      (out_conv_src_idx_o[0] == {1'b0, $past(out_conv_ch2_source_o[1:0])}))
    else $error("ch2 core source decoded wrongly");

  // Source register read returns both nibbles as they stood
  AST_RD_SRC: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R01)
    (rd_en_i && (addr_i == `ARCR_ADDR_SRC23)) |=> rd_valid_o &&
      (rd_data_o == $past({out_conv_ch3_source_o, out_conv_ch2_source_o})))
    else $error("source register readback wrong");

  // Mode register read returns pair select and both enables
  AST_RD_MODE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R03)
    (rd_en_i && (addr_i == `ARCR_ADDR_MODE)) |=> rd_valid_o &&
      (rd_data_o[3:0] == $past({in_conv_pair_select_o, out_conv_enable_o, in_conv_enable_o})))
    else $error("mode register readback wrong");

  // ADC control read returns both mute bits
  AST_RD_MUTE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R07)
    (rd_en_i && (addr_i == `ARCR_ADDR_ADC0)) |=> rd_valid_o &&
      (rd_data_o[`ARCR_MUTE1_BIT:`ARCR_MUTE0_BIT] == $past({adc_ch1_mute_o, adc_ch0_mute_o})))
    else $error("mute bits readback wrong");

  // Without a read strobe the read port falls back to zero
  AST_RD_IDLE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R11)
    !rd_en_i |=> !rd_valid_o && (rd_data_o == `ARCR_ZERO8))
    else $error("read port not idle");

  // Unmapped reads still answer, with zero
  AST_RD_UNMAPPED: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R11)
    (rd_en_i && (addr_i != `ARCR_ADDR_SRC23) && (addr_i != `ARCR_ADDR_MODE) &&
      (addr_i != `ARCR_ADDR_ADC0)) |=> rd_valid_o && (rd_data_o == `ARCR_ZERO8))
    else $error("unmapped read not zero");

  // ADC control stores the full byte even while the core runs
  AST_ADC_STORE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R11)
    wr_adc0 |=> state_ff.adc0 == $past(wr_data_i))
    else $error("ADC control write not stored");

  // With the core stopped the applied order tracks the stored bit
  AST_SINC_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R06)
    !core_run_i |=> adc_sinc_third_o == state_ff.adc0[`ARCR_SINC_BIT])
    else $error("stored sinc order not applied while stopped");

  // With the core stopped the applied rate tracks any valid stored code
  AST_FS_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R10)
    !core_run_i |=> (state_ff.adc0[`ARCR_FS_MSB:`ARCR_FS_LSB] == ARCR_FS_RSVD) ||
      (adc_pair0_sample_rate_o == state_ff.adc0[`ARCR_FS_MSB:`ARCR_FS_LSB]))
    else $error("stored rate not applied while stopped");

endmodule

/* sim/arcr_tb.sv */
// Self-checking bench for the rate-converter routing and ADC pair 0 register bank.
// Assumes arcr_pkg compiled first and arcr_consts.svh on the include path.
`timescale 1ns/1ns
`include "arcr_consts.svh"

module testbench;
  import arcr_pkg::*;

  logic clk_sys_i;
  logic reset_i;
  logic [7:0] addr_i;
  logic [7:0] wr_data_i;
  logic wr_en_i;
  logic rd_en_i;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic core_run_i;
  logic [1:0] vol_bypass_i;
  logic [3:0] src2;
  logic [3:0] src3;
  logic [1:0][1:0] cls;
  logic [1:0][2:0] idx;
  logic [1:0] pair;
  logic out_en;
  logic in_en;
  logic sinc;
  arcr_fs_t rate;
  logic mute0;
  logic mute1;
  logic [1:0] atten;
  int error_cnt;
  int num_checks;

  arcr_regs dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .core_run_i(core_run_i), .vol_bypass_i(vol_bypass_i),
    .out_conv_ch2_source_o(src2), .out_conv_ch3_source_o(src3),
    .out_conv_src_cls_o(cls), .out_conv_src_idx_o(idx), .in_conv_pair_select_o(pair),
    .out_conv_enable_o(out_en), .in_conv_enable_o(in_en), .adc_sinc_third_o(sinc),
    .adc_pair0_sample_rate_o(rate), .adc_ch0_mute_o(mute0), .adc_ch1_mute_o(mute1),
    .adc_ch_atten_max_o(atten)
  );

  // 125 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobe is raised after an edge and taken at the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    rd_en_i <= 1'b0;
  endtask

  // Lowers strobes; ends just past an edge so outputs are settled
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
      rd_en_i <= 1'b0;
    end
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    wr_en_i <= 1'b0;
    idle(1);
    chk("rd_valid", 8'h01, {7'h0, rd_valid_o});
    chk("rd_data", exp, rd_data_o);
  endtask

  // Expected decode of a source code: class and index
  function automatic logic [7:0] exp_cls(input logic [3:0] k);
    return k[3] ? 8'h02 : (k[2] ? 8'h01 : 8'h00);
  endfunction

  function automatic logic [7:0] exp_idx(input logic [3:0] k);
    return k[3] ? {5'h0, k[2:0]} : {6'h0, k[1:0]};
  endfunction

  task automatic reset_and_check();
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    chk("src2", 8'h02, {4'h0, src2});
    chk("src3", 8'h03, {4'h0, src3});
    chk("cls", 8'h00, {4'h0, cls});
    chk("idx", 8'h1A, {2'h0, idx});
    chk("mode", 8'h00, {4'h0, pair, out_en, in_en});
    chk("sinc", 8'h00, {7'h0, sinc});
    chk("rate", 8'h01, {6'h0, rate});
    chk("mute", 8'h03, {6'h0, mute1, mute0});
    chk("atten", 8'h03, {6'h0, atten});
    rd(`ARCR_ADDR_SRC23, `ARCR_RST_SRC23);
    rd(`ARCR_ADDR_MODE, `ARCR_RST_MODE);
    rd(`ARCR_ADDR_ADC0, `ARCR_RST_ADC0);
  endtask

  // Guard against a hang; tests need well under a thousand cycles
  initial begin
    #(5000 * 8);
    error_cnt++;
    final_report();
  end

  initial begin
    reset_i = 1'b1;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    core_run_i = 1'b0;
    vol_bypass_i = 2'b00;
    error_cnt = 0;
    num_checks = 0;
    reset_and_check();
    // Every source code on ch3, its complement on ch2
    for (int c = 0; c < 16; c++) begin
      wr(`ARCR_ADDR_SRC23, {c[3:0], ~c[3:0]});
      idle(1);
      chk("src3", {4'h0, c[3:0]}, {4'h0, src3});
      chk("src2", {4'h0, ~c[3:0]}, {4'h0, src2});
      idle(1);
      chk("cls3", exp_cls(c[3:0]), {6'h0, cls[1]});
      chk("idx3", exp_idx(c[3:0]), {5'h0, idx[1]});
      chk("cls2", exp_cls(~c[3:0]), {6'h0, cls[0]});
      chk("idx2", exp_idx(~c[3:0]), {5'h0, idx[0]});
    end
    // Every pair code; reserved upper bits stored, read right after write
    for (int p = 0; p < 4; p++) begin
      wr(`ARCR_ADDR_MODE, {4'hA, p[1:0], p[1:0]});
      rd(`ARCR_ADDR_MODE, {4'hA, p[1:0], p[1:0]});
      chk("pair", {6'h0, p[1:0]}, {6'h0, pair});
      chk("enables", {6'h0, p[1:0]}, {6'h0, out_en, in_en});
    end
    // Sinc and rate held while the core runs, applied once it stops
    @(posedge clk_sys_i);
    core_run_i <= 1'b1;
    wr(`ARCR_ADDR_ADC0, 8'hE6);
    rd(`ARCR_ADDR_ADC0, 8'hE6);
    chk("sinc_held", 8'h00, {7'h0, sinc});
    chk("rate_held", 8'h01, {6'h0, rate});
    chk("mute_off", 8'h00, {6'h0, mute1, mute0});
    chk("atten_off", 8'h00, {6'h0, atten});
    @(posedge clk_sys_i);
    core_run_i <= 1'b0;
    idle(1);
    chk("sinc_third", 8'h01, {7'h0, sinc});
    chk("rate_768", 8'h02, {6'h0, rate});
    wr(`ARCR_ADDR_ADC0, 8'h18);
    idle(1);
    chk("sinc_fourth", 8'h00, {7'h0, sinc});
    chk("rate_96", 8'h00, {6'h0, rate});
    chk("atten_on", 8'h03, {6'h0, atten});
    // Bypassed channels ignore their mute bit
    for (int b = 1; b < 4; b++) begin
      @(posedge clk_sys_i);
      vol_bypass_i <= b[1:0];
      idle(2);
      chk("atten_byp", {6'h0, ~b[1:0]}, {6'h0, atten});
    end
    @(posedge clk_sys_i);
    vol_bypass_i <= 2'b00;
    // Reserved rate code keeps the applied rate
    wr(`ARCR_ADDR_ADC0, 8'h1B);
    rd(`ARCR_ADDR_ADC0, 8'h1B);
    chk("rate_rsvd", 8'h00, {6'h0, rate});
    // Unmapped addresses: writes dropped, reads give zero
    wr(8'h18, 8'hFF);
    wr(8'h1C, 8'hFF);
    rd(8'h18, 8'h00);
    rd(`ARCR_ADDR_SRC23, {4'hF, 4'h0});
    rd(`ARCR_ADDR_MODE, 8'hAF);
    rd(`ARCR_ADDR_ADC0, 8'h1B);
    // Second reset mid-run restores every field; raised on an edge
    @(posedge clk_sys_i);
    reset_and_check();
    final_report();
  end
endmodule
